// >>> test_usb_device_ep_interrupt_flags.sv
`timescale 1ns/1ns
`default_nettype none
`include "uef_cfg.svh"

module test_usb_device_ep_interrupt_flags
  import uef_pkg::*;
;
  logic         clk_sys_i   = 1'b0;
  logic         sys_rst_i   = 1'b1;
  uef_bus_req_t bus_i       = '0;
  uef_usb_evt_t req         = '0;
  uef_usb_evt_t evt_i;
  logic [31:0]  rd_data_o;
  uef_irq_t     irq_o;
  int           n_mismatch  = 0;
  int           check_count = 0;
  logic [7:0]   msk;
  logic [7:0]   clr_pat;
  logic [2:0]   s;
  uef_usb_evt_t e;
  logic [7:0]   ofs [5]     = '{`UEF_OFS_MAIN, `UEF_OFS_DONE, `UEF_OFS_MASK, `UEF_OFS_ZLEN, 8'h10};
  logic [7:0]   mk [3]      = '{8'hFF, 8'h01, 8'hFE};
  logic [7:0]   dk [3]      = '{8'hFE, 8'h01, 8'h01};
  logic [7:0]   zk [3]      = '{8'hFF, 8'h01, 8'h01};

  always #25 clk_sys_i = ~clk_sys_i;

  uef_usb_host_model u_uef_usb_host_model (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .req_i(req), .evt_o(evt_i));

  uef_ep_irq_top u_uef_ep_irq_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
    .evt_i(evt_i), .rd_data_o(rd_data_o), .irq_o(irq_o));

  function automatic logic [31:0] f_main(logic [7:0] dn, logic [7:0] z, logic [2:0] st);
    return {25'h0, |dn[7:1], 2'b00, |z, st};
  endfunction

  function automatic logic [31:0] f_irq(logic [7:0] dn, logic [7:0] z, logic [7:0] m,
                                        logic [2:0] st);
    return {27'h0, |(dn & ~m & 8'hFE), |(z & ~m), st[0], st[1], st[2]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1;
    chk(rd_data_o, exp);
  endtask

  // Flag lands two edges after the request, its line one edge later
  task automatic ev(input uef_usb_evt_t x);
    @(posedge clk_sys_i);
    req <= x;
    @(posedge clk_sys_i);
    req <= '0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    void'($urandom(64742));
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    chk({27'h0, irq_o}, 32'h0000_0000);
    foreach (ofs[i])
      rc(ofs[i], 32'h0000_0000);
    $display("test reset values done");
    for (int k = 0; k < 5; k++)
    begin
      e = '0;
      e.setup_tok = (k == 0);
      e.status_pkt_rd = (k == 1);
      e.status_in_wr = (k == 2);
      e.status_zlp_rx_ok = (k == 3);
      e.status_zlp_tx_ok = (k == 4);
      s = (k == 0) ? 3'b001 : (k < 3) ? 3'b010 : 3'b100;
      ev(e);
      rc(`UEF_OFS_MAIN, f_main(8'h00, 8'h00, s));
      chk({27'h0, irq_o}, f_irq(8'h00, 8'h00, 8'h00, s));
      wr(`UEF_OFS_MAIN, {29'h0, s});
      rc(`UEF_OFS_MAIN, 32'h0000_0000);
    end
    $display("test endpoint 0 stage flags done");
    // Event and write-1-to-clear reach the flags at the same edge
    e = '0;
    e.setup_tok = 1'b1;
    e.ep_done = 8'h02;
    @(posedge clk_sys_i);
    req <= e;
    @(posedge clk_sys_i);
    req <= '0;
    bus_i <= '{addr: `UEF_OFS_MAIN, wdata: 32'h0000_004F, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i <= '0;
    rc(`UEF_OFS_MAIN, 32'h0000_0041);
    rc(`UEF_OFS_DONE, 32'h0000_0002);
    wr(`UEF_OFS_MAIN, 32'h0000_0041);
    rc(`UEF_OFS_MAIN, 32'h0000_0000);
    rc(`UEF_OFS_DONE, 32'h0000_0000);
    $display("test set against clear done");
    for (int i = 0; i < 24; i++)
    begin
      msk = (i < 3) ? mk[i] : 8'($urandom);
      e = '0;
      e.ep_done = (i < 3) ? dk[i] : 8'($urandom);
      e.zlp_rx = (i < 3) ? zk[i] : 8'($urandom);
      wr(`UEF_OFS_MASK, {24'h0, msk});
      wr(8'h14, 32'hFFFF_FFFF);
      rc(`UEF_OFS_MASK, {24'h0, msk});
      ev(e);
      rc(`UEF_OFS_DONE, {24'h0, e.ep_done & 8'hFE});
      rc(`UEF_OFS_ZLEN, {24'h0, e.zlp_rx});
      rc(`UEF_OFS_MAIN, f_main(e.ep_done, e.zlp_rx, 3'b000));
      chk({27'h0, irq_o}, f_irq(e.ep_done, e.zlp_rx, msk, 3'b000));
      clr_pat = 8'($urandom);
      wr(`UEF_OFS_DONE, {24'h0, clr_pat});
      wr(`UEF_OFS_ZLEN, {24'h0, clr_pat});
      rc(`UEF_OFS_DONE, {24'h0, e.ep_done & ~clr_pat & 8'hFE});
      rc(`UEF_OFS_ZLEN, {24'h0, e.zlp_rx & ~clr_pat});
      chk({27'h0, irq_o}, f_irq(e.ep_done & ~clr_pat, e.zlp_rx & ~clr_pat, msk, 3'b000));
      wr(`UEF_OFS_MAIN, 32'h0000_0048);
      rc(`UEF_OFS_DONE, 32'h0000_0000);
      rc(`UEF_OFS_ZLEN, 32'h0000_0000);
      chk({27'h0, irq_o}, 32'h0000_0000);
    end
    $display("test endpoint flags and masks done");
    wr(`UEF_OFS_MASK, 32'h0000_00A5);
    e = '0;
    e.setup_tok = 1'b1;
    e.ep_done = 8'h0E;
    e.zlp_rx = 8'h11;
    ev(e);
    chk({27'h0, irq_o}, f_irq(8'h0E, 8'h11, 8'hA5, 3'b001));
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    chk({27'h0, irq_o}, 32'h0000_0000);
    for (int j = 0; j < 5; j++)
      rc(ofs[j], 32'h0000_0000);
    $display("test reset in mid-run done");
    results();
  end
endmodule // test_usb_device_ep_interrupt_flags

`default_nettype wire

// >>> uef_cfg.svh
`ifndef UEF_CFG_SVH
`define UEF_CFG_SVH

`define UEF_ADDR_W        8
`define UEF_DATA_W        32
`define UEF_OFS_MAIN      8'h00
`define UEF_OFS_DONE      8'h04
`define UEF_OFS_MASK      8'h08
`define UEF_OFS_ZLEN      8'h0C
`define UEF_BIT_SETUP     0
`define UEF_BIT_STAT_PEND 1
`define UEF_BIT_STAT_DONE 2
`define UEF_BIT_ZLEN_SUM  3
`define UEF_BIT_EP_SUM    6
`define UEF_MAIN_FLAGS    5
`define UEF_RST_FLAG      1'b0
`define UEF_RST_MASK      1'b0
`define UEF_NUM_EP        8
`define UEF_MAX_PKT_BYTES 64

`endif

// >>> uef_ep_irq_top.sv
// Summary of operation
// - The status-done flag (bit 2) is set when the endpoint 0 status stage ends successfully.
// - Status-done is set after a zero-length packet is received (read) or sent (write) there.
// - The status-pending flag (bit 1) is set when a status packet arrives in a read transfer.
// - In a write transfer the status-stage IN token also raises status-pending to end the data.
// - The setup flag (bit 0) is set whenever a SETUP token arrives for endpoint 0.
// - Endpoint-done bits 7-1 are set when a transfer on endpoints 1 to 7 succeeds.
// - A mask bit of 0 lets its endpoint drive the interrupt lines and 1 suppresses it.
// - Masks gate done flags onto the done line and zero-length flags onto the zero-length line.
// - A masked endpoint still gets its done bit set but does not raise the done line.
// - A masked endpoint still gets its zero-length bit set but does not raise that line.
// - Mask bit 0 acts only on the zero-length path since endpoint 0 has no done bit.
// - Writing 1 to the summary done bit of the main register clears every done bit not set by an event in that same cycle.
// - The summary done bit is set when any endpoint other than 0 completes a transfer.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "uef_cfg.svh"

module uef_ep_irq_top
  import uef_pkg::*;
#(
  parameter int N_EP = `UEF_NUM_EP
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire uef_bus_req_t bus_i,
  input  wire uef_usb_evt_t evt_i,
  output logic [31:0]       rd_data_o,
  output uef_irq_t          irq_o
);

  typedef struct packed {
    logic [N_EP-1:0] mask;
    logic [31:0]     rd_data;
    uef_irq_t        irq;
  } uef_top_st_t;

  localparam int MF = `UEF_MAIN_FLAGS;

  uef_top_st_t     st_r;
  uef_top_st_t     st_nxt;

  logic [MF-1:0]   main_set;
  logic [MF-1:0]   main_clr;
  logic [MF-1:0]   main_q;
  logic [N_EP-1:0] done_set;
  logic [N_EP-1:0] done_clr;
  logic [N_EP-1:0] done_q;
  logic [N_EP-1:0] zlen_set;
  logic [N_EP-1:0] zlen_clr;
  logic [N_EP-1:0] zlen_q;
  logic [N_EP-1:0] done_mask;
  logic            ep_gate_c;
  logic            zl_gate_c;
  logic            wr_main;
  logic            wr_done;
  logic            wr_mask;
  logic            wr_zlen;
  logic [31:0]     rd_mux;
  logic [7:0]      main_view;

  if (N_EP < 2 || N_EP > 8)
  begin : g_chk
    $error("uef_ep_irq_top: N_EP must be 2 to 8");
  end

  // Main flag slots inside the sticky bank
  localparam int S_SETUP = 0;
  localparam int S_PEND  = 1;
  localparam int S_SDONE = 2;
  localparam int S_ZSUM  = 3;
  localparam int S_EPSUM = 4;

  // Register write decode
  always_comb
  begin
    wr_main = 1'b0;
    wr_done = 1'b0;
    wr_mask = 1'b0;
    wr_zlen = 1'b0;
    if (bus_i.wr && bus_i.addr == `UEF_OFS_MAIN)
      wr_main = 1'b1;
    else if (bus_i.wr && bus_i.addr == `UEF_OFS_DONE)
      wr_done = 1'b1;
    else if (bus_i.wr && bus_i.addr == `UEF_OFS_MASK)
      wr_mask = 1'b1;
    else if (bus_i.wr && bus_i.addr == `UEF_OFS_ZLEN)
      wr_zlen = 1'b1;
  end

  // Event qualification for the main flags
  always_comb
  begin
    main_set          = '0;
    main_set[S_SETUP] = evt_i.setup_tok;
    main_set[S_PEND]  = evt_i.status_pkt_rd | evt_i.status_in_wr;
    main_set[S_SDONE] = evt_i.status_zlp_rx_ok | evt_i.status_zlp_tx_ok;
    main_set[S_ZSUM]  = |zlen_set;
    main_set[S_EPSUM] = |done_set;
  end

  // Write 1 to clear on the main register
  always_comb
  begin
    main_clr          = '0;
    main_clr[S_SETUP] = wr_main & bus_i.wdata[`UEF_BIT_SETUP];
    main_clr[S_PEND]  = wr_main & bus_i.wdata[`UEF_BIT_STAT_PEND];
    main_clr[S_SDONE] = wr_main & bus_i.wdata[`UEF_BIT_STAT_DONE];
    main_clr[S_ZSUM]  = wr_main & bus_i.wdata[`UEF_BIT_ZLEN_SUM];
    main_clr[S_EPSUM] = wr_main & bus_i.wdata[`UEF_BIT_EP_SUM];
  end

  // Endpoint 0 has no done bit
  always_comb
  begin
    done_set    = evt_i.ep_done[N_EP-1:0];
    done_set[0] = 1'b0;
    zlen_set    = evt_i.zlp_rx[N_EP-1:0];
  end

  // Per-endpoint clears: own register W1C, or summary bit clears all
  always_comb
  begin
    done_clr = {N_EP{main_clr[S_EPSUM]}};
    zlen_clr = {N_EP{main_clr[S_ZSUM]}};
    if (wr_done)
      done_clr = done_clr | bus_i.wdata[N_EP-1:0];
    if (wr_zlen)
      zlen_clr = zlen_clr | bus_i.wdata[N_EP-1:0];
  end

  uef_sticky_flags #(
    .N (MF)
  ) u_main_flags (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (main_set),
    .clr_i     (main_clr),
    .flags_o   (main_q)
  );

  uef_sticky_flags #(
    .N (N_EP)
  ) u_done_flags (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (done_set),
    .clr_i     (done_clr),
    .flags_o   (done_q)
  );

  uef_sticky_flags #(
    .N (N_EP)
  ) u_zlen_flags (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (zlen_set),
    .clr_i     (zlen_clr),
    .flags_o   (zlen_q)
  );

  // Mask bit 0 never reaches the done line
  always_comb
  begin
    done_mask    = st_r.mask;
    done_mask[0] = 1'b1;
  end

  uef_irq_gate #(
    .N (N_EP)
  ) u_ep_gate (
    .flags_i (done_q),
    .mask_i  (done_mask),
    .irq_o   (ep_gate_c)
  );

  uef_irq_gate #(
    .N (N_EP)
  ) u_zl_gate (
    .flags_i (zlen_q),
    .mask_i  (st_r.mask),
    .irq_o   (zl_gate_c)
  );

  // Read view of the main register
  always_comb
  begin
    main_view                     = '0;
    main_view[`UEF_BIT_SETUP]     = main_q[S_SETUP];
    main_view[`UEF_BIT_STAT_PEND] = main_q[S_PEND];
    main_view[`UEF_BIT_STAT_DONE] = main_q[S_SDONE];
    main_view[`UEF_BIT_ZLEN_SUM]  = main_q[S_ZSUM];
    main_view[`UEF_BIT_EP_SUM]    = main_q[S_EPSUM];
  end

  // Read decode; unmapped addresses and reserved bits read 0
  always_comb
  begin
    rd_mux = '0;
    if (bus_i.addr == `UEF_OFS_MAIN)
      rd_mux[7:0] = main_view;
    else if (bus_i.addr == `UEF_OFS_DONE)
      rd_mux[N_EP-1:0] = done_q & ~N_EP'(1);
    else if (bus_i.addr == `UEF_OFS_MASK)
      rd_mux[N_EP-1:0] = st_r.mask;
    else if (bus_i.addr == `UEF_OFS_ZLEN)
      rd_mux[N_EP-1:0] = zlen_q;
  end

  always_comb
  begin
    st_nxt = st_r;
    if (wr_mask)
      st_nxt.mask = bus_i.wdata[N_EP-1:0];
    // Read data stands for exactly one cycle
    st_nxt.rd_data         = bus_i.rd ? rd_mux : '0;
    st_nxt.irq.ep_done     = ep_gate_c;
    st_nxt.irq.zero_len    = zl_gate_c;
    st_nxt.irq.setup       = main_q[S_SETUP];
    st_nxt.irq.status_pend = main_q[S_PEND];
    st_nxt.irq.status_done = main_q[S_SDONE];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      st_r.mask    <= {N_EP{`UEF_RST_MASK}};
      st_r.rd_data <= '0;
      st_r.irq     <= '0;
    end
    else
      st_r <= st_nxt;
  end

  assign rd_data_o = st_r.rd_data;
  assign irq_o     = st_r.irq;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_setup_seen;
    evt_i.setup_tok && !main_clr[S_SETUP];
  endsequence

  sequence s_status_pkt;
    evt_i.status_pkt_rd || evt_i.status_in_wr;
  endsequence

  sequence s_status_end;
    evt_i.status_zlp_rx_ok || evt_i.status_zlp_tx_ok;
  endsequence

  sequence s_ep_clear_all;
    wr_main && bus_i.wdata[`UEF_BIT_EP_SUM] && (done_set == '0);
  endsequence

  AST_SETUP_SET: assert property (
    s_setup_seen |=> main_q[S_SETUP] ##1 (irq_o.setup || main_clr[S_SETUP]))
    else $error("setup flag not raised");

  AST_PEND_SET: assert property (
    s_status_pkt |=> main_q[S_PEND])
    else $error("status pending flag not raised");

  AST_STAT_DONE_SET: assert property (
    s_status_end |=> main_q[S_SDONE] && main_view[`UEF_BIT_STAT_DONE])
    else $error("status done flag not raised");

  AST_EP_DONE_SET: assert property (
    (done_set != '0) |=> ((done_q & $past(done_set)) == $past(done_set))
      && main_q[S_EPSUM])
    else $error("endpoint done bits or summary not raised");

  AST_EP_BIT0_ZERO: assert property (
    !done_q[0] && !(zlen_q == N_EP'(1) && st_r.mask[0] && irq_o.zero_len
      && $past(zlen_q == N_EP'(1) && st_r.mask[0])))
    else $error("endpoint 0 done path active");

  AST_SUM_CLEAR: assert property (
    s_ep_clear_all |=> (done_q == '0) && !main_q[S_EPSUM])
    else $error("summary clear left done bits");

  AST_EP_LINE: assert property (
    ((done_q & ~done_mask) != '0) |=> irq_o.ep_done)
    else $error("done line low with unmasked flag");

  AST_EP_MASKED: assert property (
    ((done_q & ~done_mask) == '0) |=> !irq_o.ep_done)
    else $error("done line high while all flags masked");

  AST_ZL_MASKED: assert property (
    ((zlen_q & ~st_r.mask) == '0) && (zlen_q != '0) |=> !irq_o.zero_len)
    else $error("zero-length line high while masked");

  AST_MASK_READ: assert property (
    (bus_i.rd && bus_i.addr == `UEF_OFS_MASK && !$past(wr_mask))
      |=> rd_data_o[N_EP-1:0] == $past(st_r.mask) ##1 rd_data_o == '0
        || $past(bus_i.rd))
    else $error("mask readback wrong");

  AST_RESET_CLEAN: assert property (
    disable iff (1'b0)
    sys_rst_i |=> (main_q == '0) && (done_q == '0) && (zlen_q == '0)
      && (st_r.mask == '0) && (irq_o == '0))
    else $error("state not cleared by reset");

endmodule // uef_ep_irq_top
`default_nettype wire

// >>> uef_irq_gate.sv
`timescale 1ns/1ns
`default_nettype none

module uef_irq_gate
  import uef_pkg::*;
#(
  parameter int N = 8
)
(
  input  wire logic [N-1:0] flags_i,
  input  wire logic [N-1:0] mask_i,
  output logic              irq_o
);

  logic [N-1:0] pass;

  if (N < 1 || N > 32)
  begin : g_chk
    $error("uef_irq_gate: N out of range");
  end

  // A mask bit of 1 suppresses the endpoint
  for (genvar i = 0; i < N; i++)
  begin : g_bit
    assign pass[i] = flags_i[i] & ~mask_i[i];
  end

  assign irq_o = |pass;

endmodule // uef_irq_gate

// >>> uef_pkg.sv
package uef_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } uef_bus_req_t;

  // One-cycle pulses from the controller core, same clock
  typedef struct packed {
    logic       setup_tok;
    logic       status_pkt_rd;
    logic       status_in_wr;
    logic       status_zlp_rx_ok;
    logic       status_zlp_tx_ok;
    logic [7:0] ep_done;
    logic [7:0] zlp_rx;
  } uef_usb_evt_t;

  typedef struct packed {
    logic ep_done;
    logic zero_len;
    logic setup;
    logic status_pend;
    logic status_done;
  } uef_irq_t;

endpackage : uef_pkg

// >>> uef_sticky_flags.sv
`timescale 1ns/1ns
`default_nettype none
`include "uef_cfg.svh"

module uef_sticky_flags
  import uef_pkg::*;
#(
  parameter int N = 8
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic      [N-1:0] flags_o
);

  typedef struct packed {
    logic [N-1:0] flags;
  } uef_sticky_st_t;

  uef_sticky_st_t st_r;
  uef_sticky_st_t st_nxt;
  logic [N-1:0]   bit_nxt;

  if (N < 1 || N > 32)
  begin : g_chk
    $error("uef_sticky_flags: N out of range");
  end

  // Set wins over a clear in the same cycle
  for (genvar i = 0; i < N; i++)
  begin : g_bit
    assign bit_nxt[i] = set_i[i] | (st_r.flags[i] & ~clr_i[i]);
  end

  always_comb
  begin
    st_nxt.flags = bit_nxt;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      st_r.flags <= {N{`UEF_RST_FLAG}};
    else
      st_r <= st_nxt;
  end

  assign flags_o = st_r.flags;

endmodule // uef_sticky_flags

// >>> uef_usb_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module uef_usb_host_model
  import uef_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire uef_usb_evt_t req_i,
  output uef_usb_evt_t      evt_o
);
  // Bus traffic seen by the core turns into one-cycle event pulses
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      evt_o <= '0;
    else
      evt_o <= req_i;
  end
endmodule // uef_usb_host_model

`default_nettype wire
